/* File: ptvs_far_model.sv */
// Model of the shutdown controller on the far side
`timescale 1ns/1ps
module ptvs_far_model #(
  parameter int ACK_DELAY = 5
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Handshake
  input wire logic shutdown_trigger_in,
  output logic shutdown_ack_out,
  output logic [3:0] trig_count_out
);
  logic [3:0] cnt;
  // Ack comes late and drops again, so a design must really wait for it
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= 4'h0;
      shutdown_ack_out <= 1'b0;
      trig_count_out <= 4'h0;
    end else if (shutdown_trigger_in) begin
      cnt <= 4'h1;
      trig_count_out <= trig_count_out + 4'h1;
    end else if (cnt != 4'h0 && cnt != 4'hf) begin
      cnt <= cnt + 4'h1;
      shutdown_ack_out <= (cnt >= ACK_DELAY) && (cnt < ACK_DELAY + 4);
    end else begin
      shutdown_ack_out <= 1'b0;
    end
  end
endmodule

/* File: ptvs_pkg.sv */
// Package of constants for the power transition value set sequencer
package ptvs_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_STEPS = 6;
  localparam int MEM_AW = 4;
  localparam int MEM_W = 48;
  // ----------------------------------------------------------------
  // Register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_CORE_MON = 8'h43;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_MON = 8'h44;
  localparam int SHADOW_SEL_BIT = 7;
  localparam int SHADOW_SEQ_BIT = 5;
  localparam int SHADOW_STEP_LSB = 2;
  localparam logic [1:0] KIND_STEP = 2'h0;
  localparam logic [1:0] KIND_CORE = 2'h1;
  localparam logic [1:0] KIND_MAIN = 2'h2;
  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_A_BIT = 0;
  localparam int CTRL_B_BIT = 1;
  localparam int CTRL_GSC_BIT = 2;
  localparam int CTRL_PEND_BIT = 3;
  localparam int STAT_LAST_BIT = 0;
  localparam int STAT_CLK_BIT = 1;
  localparam int STAT_STEP_LSB = 4;
  localparam int STAT_STATE_LSB = 8;
  // ----------------------------------------------------------------
  // Step value fields
  // ----------------------------------------------------------------
  localparam int CORE_FIELD_LSB = 3;
  localparam int MAIN_FIELD_LSB = 0;
  localparam int WAIT_FIELD_LSB = 8;
  localparam int DIV_BIT = 13;
  localparam logic [2:0] CORE_CLK_STOP = 3'h7;
  localparam logic [2:0] CORE_CLK_RUN = 3'h6;
  localparam logic [DATA_W-1:0] STEP_DISABLED = 16'h0000;
  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] DIV_WAIT_CYCLES = 7'h40;
  localparam logic [DATA_W-1:0] RESET_STEP = 16'h0000;
  localparam logic [DATA_W-1:0] RESET_MON = 16'h0000;
  localparam logic RESET_LAST_SEQ = 1'b1;

  typedef enum logic [2:0] {
    PTVS_IDLE  = 3'b000,
    PTVS_FETCH = 3'b001,
    PTVS_APPLY = 3'b010,
    PTVS_WAIT  = 3'b011,
    PTVS_GSC   = 3'b100
  } ptvs_state_e;

  // Three-bit regulator field at a given position of a step value
  function automatic logic [2:0] ptvs_field3(input logic [DATA_W-1:0] v, input int lsb);
    ptvs_field3 = v[lsb +: 3];
  endfunction
endpackage

/* File: ptvs_sequencer.sv */
// Power transition sequencer copying shadow value sets into supply controls
`timescale 1ns/1ps
module ptvs_sequencer (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [ptvs_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ptvs_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ptvs_pkg::DATA_W-1:0] reg_rdata_out,
  // Wakeup request pin and shutdown controller
  input wire logic wakeup_request_in,
  input wire logic shutdown_ack_in,
  output logic shutdown_trigger_out,
  // Supply control registers
  output logic [ptvs_pkg::DATA_W-1:0] active_step_control_out,
  output logic [ptvs_pkg::DATA_W-1:0] core_monitor_control_out,
  output logic [ptvs_pkg::DATA_W-1:0] main_monitor_control_out,
  // Core domain clock and processor
  output logic core_clock_enable_out,
  output logic cpu_halt_out
);
  import ptvs_pkg::*;

  ptvs_shadow_if sh ();

  ptvs_shadow_mem u_mem (
    .sys_clk_in(sys_clk_in),
    .clk_en_in(clk_en_in),
    .sh(sh)
  );

  ptvs_state_e state, next_state;
  logic seq_b_active, next_seq_b_active;
  logic [2:0] step, next_step;
  logic [6:0] wait_cnt, next_wait_cnt;
  logic seq_a_en, next_seq_a_en;
  logic seq_b_en, next_seq_b_en;
  logic b_pending, next_b_pending;
  logic last_seq, next_last_seq;
  logic gsc_enable, next_gsc_enable;
  logic core_clk_on, next_core_clk_on;
  logic gsc_trig, next_gsc_trig;
  logic [DATA_W-1:0] step_reg, next_step_reg;
  logic [DATA_W-1:0] core_mon, next_core_mon;
  logic [DATA_W-1:0] main_mon, next_main_mon;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic wake_ff1, wake_ff2, wake_ff3;
  logic ack_ff1, ack_ff2;
  logic wake_rise;
  logic [DATA_W-1:0] fetched_step;
  logic is_shadow;
  logic [1:0] shadow_kind;
  logic advance;
  logic [6:0] step_wait;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // First stages feed only the second stages; the edge detector uses later ones
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_ff1 <= 1'b0;
      wake_ff2 <= 1'b0;
      wake_ff3 <= 1'b0;
      ack_ff1 <= 1'b0;
      ack_ff2 <= 1'b0;
    end else if (clk_en_in) begin
      wake_ff1 <= wakeup_request_in;
      wake_ff2 <= wake_ff1;
      wake_ff3 <= wake_ff2;
      ack_ff1 <= shutdown_ack_in;
      ack_ff2 <= ack_ff1;
    end
  end

  assign wake_rise = wake_ff2 & ~wake_ff3;

  // ----------------------------------------------------------------
  // Shadow memory access
  // ----------------------------------------------------------------
  // Shadows are write only, so the single read port belongs to the sequencer
  assign is_shadow = ~reg_addr_in[SHADOW_SEL_BIT] && (reg_addr_in[6] == 1'b0);
  assign shadow_kind = reg_addr_in[1:0];
  assign sh.wr_addr = {reg_addr_in[SHADOW_SEQ_BIT], reg_addr_in[SHADOW_STEP_LSB +: 3]};
  assign sh.wr_data = reg_wdata_in;
  assign sh.wr_lane[0] = reg_wr_in && is_shadow && (shadow_kind == KIND_STEP);
  assign sh.wr_lane[1] = reg_wr_in && is_shadow && (shadow_kind == KIND_CORE);
  assign sh.wr_lane[2] = reg_wr_in && is_shadow && (shadow_kind == KIND_MAIN);
  assign sh.rd_addr = {seq_b_active, step};
  assign sh.rd_en = (state == PTVS_FETCH);
  assign fetched_step = sh.rd_data[DATA_W-1:0];

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_seq_b_active = seq_b_active;
    next_step = step;
    next_wait_cnt = wait_cnt;
    next_seq_a_en = seq_a_en;
    next_seq_b_en = seq_b_en;
    next_b_pending = b_pending;
    next_last_seq = last_seq;
    next_gsc_enable = gsc_enable;
    next_core_clk_on = core_clk_on;
    next_gsc_trig = 1'b0;
    next_step_reg = step_reg;
    next_core_mon = core_mon;
    next_main_mon = main_mon;
    advance = 1'b0;
    step_wait = 7'h00;
    // Wakeup pin or software both request sequence B; it waits for A
    if (wake_rise || (reg_wr_in && reg_addr_in == ADDR_CTRL && reg_wdata_in[CTRL_B_BIT])) begin
      next_b_pending = 1'b1;
    end
    if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
      next_gsc_enable = reg_wdata_in[CTRL_GSC_BIT];
    end
    case (state)
      PTVS_IDLE: begin
        // A is started by software only; while busy a trigger is ignored
        if (reg_wr_in && reg_addr_in == ADDR_CTRL && reg_wdata_in[CTRL_A_BIT]) begin
          next_state = PTVS_FETCH;
          next_seq_b_active = 1'b0;
          next_seq_a_en = 1'b1;
          next_step = 3'h0;
        end else if (b_pending && !last_seq) begin
          next_state = PTVS_FETCH;
          next_seq_b_active = 1'b1;
          next_seq_b_en = 1'b1;
          next_b_pending = 1'b0;
          next_step = 3'h0;
        end
      end
      PTVS_FETCH: begin
        next_state = PTVS_APPLY; // First of two cycles per step
      end
      PTVS_APPLY: begin
        // All three registers copied in parallel zero value skips
        if (fetched_step != STEP_DISABLED) begin
          next_step_reg = fetched_step;
          next_core_mon = sh.rd_data[DATA_W +: DATA_W];
          next_main_mon = sh.rd_data[2*DATA_W +: DATA_W];
          if (ptvs_field3(fetched_step, CORE_FIELD_LSB) == CORE_CLK_STOP) begin
            next_core_clk_on = 1'b0;
          end else if (ptvs_field3(fetched_step, CORE_FIELD_LSB) == CORE_CLK_RUN) begin
            next_core_clk_on = 1'b1;
          end
          if (fetched_step[DIV_BIT]) begin
            step_wait = DIV_WAIT_CYCLES;
          end else begin
            step_wait = {5'h00, fetched_step[WAIT_FIELD_LSB +: 2]};
          end
        end
        // The copy itself is the two cycles; WAIT holds only extra cycles
        next_wait_cnt = step_wait;
        if (step_wait != 7'h00) begin
          next_state = PTVS_WAIT;
        end else begin
          advance = 1'b1;
        end
      end
      PTVS_WAIT: begin
        if (wait_cnt > 7'h01) begin
          next_wait_cnt = wait_cnt - 7'h01;
        end else begin
          next_wait_cnt = 7'h00;
          advance = 1'b1;
        end
      end
      PTVS_GSC: begin
        // Only reached with the controller enabled; waits for its ack
        if (ack_ff2) begin
          next_state = PTVS_IDLE;
          next_seq_a_en = 1'b0;
          next_seq_b_en = 1'b0;
          next_last_seq = 1'b1;
        end
      end
      default: begin
        next_state = PTVS_IDLE;
      end
    endcase
    // Step advance, shared by a copy or disabled-step skip without extra wait and the end of a wait
    if (advance) begin
      if (step == 3'(NUM_STEPS - 1)) begin
        // Sequence A or bypassed controller: go straight home, no trigger
        if (gsc_enable && seq_b_active) begin
          next_gsc_trig = 1'b1;
          next_state = PTVS_GSC;
        end else begin
          next_state = PTVS_IDLE;
          next_seq_a_en = 1'b0;
          next_seq_b_en = 1'b0;
          next_last_seq = seq_b_active;
        end
      end else begin
        next_step = step + 3'h1;
        next_state = PTVS_FETCH;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Unmapped and shadow addresses read as zero
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_CTRL: begin
          next_rdata[CTRL_A_BIT] = seq_a_en;
          next_rdata[CTRL_B_BIT] = seq_b_en;
          next_rdata[CTRL_GSC_BIT] = gsc_enable;
          next_rdata[CTRL_PEND_BIT] = b_pending;
        end
        ADDR_STATUS: begin
          next_rdata[STAT_LAST_BIT] = last_seq;
          next_rdata[STAT_CLK_BIT] = core_clk_on;
          next_rdata[STAT_STEP_LSB +: 3] = step;
          next_rdata[STAT_STATE_LSB +: 3] = state;
        end
        ADDR_STEP: next_rdata = step_reg;
        ADDR_CORE_MON: next_rdata = core_mon;
        ADDR_MAIN_MON: next_rdata = main_mon;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= PTVS_IDLE;
      seq_b_active <= 1'b0;
      step <= 3'h0;
      wait_cnt <= 7'h00;
      seq_a_en <= 1'b0;
      seq_b_en <= 1'b0;
      b_pending <= 1'b0;
      last_seq <= RESET_LAST_SEQ;
      gsc_enable <= 1'b0;
      core_clk_on <= 1'b1;
      gsc_trig <= 1'b0;
      step_reg <= RESET_STEP;
      core_mon <= RESET_MON;
      main_mon <= RESET_MON;
      rdata <= 16'h0000;
    end else if (clk_en_in) begin
      state <= next_state;
      seq_b_active <= next_seq_b_active;
      step <= next_step;
      wait_cnt <= next_wait_cnt;
      seq_a_en <= next_seq_a_en;
      seq_b_en <= next_seq_b_en;
      b_pending <= next_b_pending;
      last_seq <= next_last_seq;
      gsc_enable <= next_gsc_enable;
      core_clk_on <= next_core_clk_on;
      gsc_trig <= next_gsc_trig;
      step_reg <= next_step_reg;
      core_mon <= next_core_mon;
      main_mon <= next_main_mon;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out = rdata;
  assign shutdown_trigger_out = gsc_trig;
  assign active_step_control_out = step_reg;
  assign core_monitor_control_out = core_mon;
  assign main_monitor_control_out = main_mon;
  assign core_clock_enable_out = core_clk_on;
  // Debug clocks keep running, but the processor sits still
  assign cpu_halt_out = ~core_clk_on;
endmodule

/* File: ptvs_sequencer_assertions.sv */
// Port checker of the power transition sequencer
`timescale 1ns/1ps
module ptvs_sequencer_assertions (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [ptvs_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ptvs_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ptvs_pkg::DATA_W-1:0] reg_rdata_out,
  // Wakeup and shutdown controller
  input wire logic wakeup_request_in,
  input wire logic shutdown_ack_in,
  input wire logic shutdown_trigger_out,
  // Supply controls
  input wire logic [ptvs_pkg::DATA_W-1:0] active_step_control_out,
  input wire logic [ptvs_pkg::DATA_W-1:0] core_monitor_control_out,
  input wire logic [ptvs_pkg::DATA_W-1:0] main_monitor_control_out,
  input wire logic core_clock_enable_out,
  input wire logic cpu_halt_out
);
  import ptvs_pkg::*;
  logic [DATA_W-1:0] prev_step;
  logic [6:0] gap;
  logic gsc_on;
  logic chg;
  // ----
  // Helper logic
  // ----
  // A copy is only visible when the value differs, so gaps are upper bounds
  assign chg = active_step_control_out != prev_step;
  // Edges since the last visible copy, saturating so idle time never wraps
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_step <= '0;
      gap <= 7'h7f;
      gsc_on <= 1'b0;
    end else begin
      prev_step <= active_step_control_out;
      if (chg) begin
        gap <= 7'h01;
      end else if (gap != 7'h7f) begin
        gap <= gap + 7'h01;
      end
      if (clk_en_in && reg_wr_in && reg_addr_in == ADDR_CTRL) begin
        gsc_on <= reg_wdata_in[CTRL_GSC_BIT];
      end
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  property p_halt;
    cpu_halt_out == !core_clock_enable_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt does not follow core clock");
  property p_stop;
    chg && active_step_control_out[CORE_FIELD_LSB +: 3] == CORE_CLK_STOP
      |-> !core_clock_enable_out;
  endproperty
  a_stop: assert property (p_stop)
    else $error("core clock not stopped");
  property p_run;
    chg && active_step_control_out[CORE_FIELD_LSB +: 3] == CORE_CLK_RUN
      |-> core_clock_enable_out;
  endproperty
  a_run: assert property (p_run)
    else $error("core clock not restarted");
  property p_gap;
    chg |-> gap >= 7'd2;
  endproperty
  a_gap: assert property (p_gap)
    else $error("copies too close");
  property p_div;
    chg && prev_step[DIV_BIT] |-> gap >= 7'd66;
  endproperty
  a_div: assert property (p_div)
    else $error("divide wait too short");
  property p_zero;
    chg |-> active_step_control_out != STEP_DISABLED;
  endproperty
  a_zero: assert property (p_zero)
    else $error("disabled step was copied");
  property p_gsc;
    shutdown_trigger_out |-> gsc_on ##1 !shutdown_trigger_out;
  endproperty
  a_gsc: assert property (p_gsc)
    else $error("bad shutdown trigger");
  property p_rd_step;
    clk_en_in && reg_rd_in && reg_addr_in == ADDR_STEP
      |=> reg_rdata_out == $past(active_step_control_out);
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("step readback wrong");
  property p_rd_clk;
    clk_en_in && reg_rd_in && reg_addr_in == ADDR_STATUS
      |=> reg_rdata_out[STAT_CLK_BIT] == $past(core_clock_enable_out);
  endproperty
  a_rd_clk: assert property (p_rd_clk)
    else $error("clock status wrong");
endmodule
bind ptvs_sequencer ptvs_sequencer_assertions u_chk (.sys_clk_in, .resetn_in, .clk_en_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .wakeup_request_in,
  .shutdown_ack_in, .shutdown_trigger_out, .active_step_control_out,
  .core_monitor_control_out, .main_monitor_control_out, .core_clock_enable_out,
  .cpu_halt_out);

/* File: ptvs_sequencer_bench.sv */
// Self-checking bench of the power transition sequencer
`timescale 1ns/1ps
module ptvs_sequencer_bench;
  import ptvs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic wakeup_request_in = 1'b0;
  logic ack, trig, clk_on, halt;
  logic [3:0] trigs;
  logic [DATA_W-1:0] rdata, step_o, cmon, mmon;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int t0 = 0;
  ptvs_sequencer dut (.sys_clk_in, .resetn_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out(rdata), .wakeup_request_in,
    .shutdown_ack_in(ack), .shutdown_trigger_out(trig), .active_step_control_out(step_o),
    .core_monitor_control_out(cmon), .main_monitor_control_out(mmon),
    .core_clock_enable_out(clk_on), .cpu_halt_out(halt));
  ptvs_far_model far (.sys_clk_in, .resetn_in, .shutdown_trigger_in(trig),
    .shutdown_ack_out(ack), .trig_count_out(trigs));
  // ----
  // Clock and helpers
  // ----
  // One tick stands for one slow wakeup clock cycle; only counts are judged
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, r, input logic [7:0] a, input logic [15:0] d);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
  endtask
  // Strobe drops for one edge so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
    reg_wr_in <= 1'b0;
    #1 t0 = cyc;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    bus(1'b0, 1'b1, a, '0);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    d = rdata;
    @(posedge sys_clk_in);
  endtask
  task automatic prog(input logic sq, input int ix, input logic [15:0] sv, mv,
                      input logic mon);
    wr({2'b00, sq, 3'(ix), KIND_STEP}, sv);
    if (mon) begin
      wr({2'b00, sq, 3'(ix), KIND_CORE}, mv);
      wr({2'b00, sq, 3'(ix), KIND_MAIN}, mv);
    end
  endtask
  // Waits for a copied value; exp below zero skips the timing compare
  task automatic wait_val(input logic [15:0] v, input int exp);
    int n;
    n = 0;
    while (step_o !== v && n < 300) begin
      @(posedge sys_clk_in);
      #1 n++;
    end
    if (n >= 300) begin
      err_total++;
      final_report();
    end
    if (exp >= 0) chk(16'(cyc - t0), 16'(exp), "copy time");
  endtask
  task automatic wait_idle();
    logic [15:0] s;
    int n;
    n = 0;
    s = 16'hffff;
    while (s[STAT_STATE_LSB +: 3] !== 3'h0 && n < 100) begin
      rd(ADDR_STATUS, s);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      final_report();
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_reset();
    logic [15:0] d;
    chk(step_o, STEP_DISABLED, "step reset");
    chk({15'h0, clk_on, halt}, 16'h2, "clock reset");
    rd(ADDR_STATUS, d);
    chk({14'h0, d[STAT_CLK_BIT], d[STAT_LAST_BIT]}, 16'h3, "status reset");
    wr(8'h00, 16'h1234);
    rd(8'h00, d);
    chk(d, 16'h0, "shadow read");
    rd(8'h50, d);
    chk(d, 16'h0, "unmapped read");
  endtask
  // Reference switch: steps 1 to 4 active, 5 and 6 disabled
  task automatic s_ref(input logic [63:0] v);
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      prog(1'b0, i, v[63-16*i -: 16], (i == 3) ? 16'h2544 : 16'h0504, 1'b1);
    end
    for (int i = 4; i < 6; i++) prog(1'b0, i, STEP_DISABLED, '0, 1'b0);
    wr(ADDR_CTRL, 16'h0001);
    wait_val(v[63:48], 2);
    chk(cmon, 16'h0504, "core monitors off");
    chk(mmon, 16'h0504, "main monitors off");
    chk({15'h0, clk_on, halt}, 16'h1, "core clock stop");
    wait_val(v[47:32], 4);
    wait_val(v[15:0], 8);
    chk(cmon, 16'h2544, "core monitors on");
    chk(mmon, 16'h2544, "main monitors on");
    chk({15'h0, clk_on, halt}, 16'h2, "core clock run");
    wait_idle();
    chk(step_o, v[15:0], "disabled steps");
    rd(ADDR_STEP, d);
    chk(d, v[15:0], "step read");
    rd(ADDR_CTRL, d);
    chk({15'h0, d[CTRL_A_BIT]}, 16'h0, "A enable");
    rd(ADDR_STATUS, d);
    chk({15'h0, d[STAT_LAST_BIT]}, 16'h0, "last flag");
  endtask
  task automatic s_wait();
    prog(1'b0, 0, 16'h0100, '0, 1'b0);
    prog(1'b0, 1, 16'h2001, '0, 1'b0);
    prog(1'b0, 2, 16'h0002, '0, 1'b0);
    for (int i = 3; i < 6; i++) prog(1'b0, i, STEP_DISABLED, '0, 1'b0);
    wr(ADDR_CTRL, 16'h0001);
    wait_val(16'h0100, 2);
    wait_val(16'h2001, 5);
    // Ten frozen edges inside the divide wait push the next copy back by ten
    clk_en_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    clk_en_in <= 1'b1;
    wait_val(16'h0002, 81);
    wait_idle();
    chk({12'h0, trigs}, 16'h0, "no trigger bypassed");
  endtask
  // Clock-stop entry by A, wakeup by B held pending behind A
  task automatic s_stop();
    logic [15:0] d;
    for (int i = 0; i < 3; i++) prog(1'b0, i, STEP_DISABLED, '0, 1'b0);
    prog(1'b0, 3, 16'h80fb, 16'h2544, 1'b1);
    for (int i = 4; i < 6; i++) prog(1'b0, i, STEP_DISABLED, '0, 1'b0);
    prog(1'b1, 0, 16'h80f3, 16'h2544, 1'b1);
    for (int i = 1; i < 6; i++) prog(1'b1, i, STEP_DISABLED, '0, 1'b0);
    wr(ADDR_CTRL, 16'h0005);
    wakeup_request_in <= 1'b1;
    wait_val(16'h80fb, 8);
    chk({15'h0, clk_on, halt}, 16'h1, "stopped");
    rd(ADDR_CTRL, d);
    chk({12'h0, d[3:0]}, 16'h000d, "B pending");
    wakeup_request_in <= 1'b0;
    wait_val(16'h80f3, -1);
    chk({15'h0, clk_on, halt}, 16'h2, "woken");
    wait_idle();
    chk({12'h0, trigs}, 16'h1, "trigger at B exit");
    rd(ADDR_STATUS, d);
    chk({15'h0, d[STAT_LAST_BIT]}, 16'h1, "last is B");
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    s_reset();
    s_ref({16'h80f8, 16'h80db, 16'h80db, 16'h80f3});
    s_ref({16'h80fb, 16'h80c0, 16'h80c0, 16'h80f0});
    s_wait();
    s_stop();
    final_report();
  end
endmodule

/* File: ptvs_shadow_if.sv */
// Carrier between the sequencer and its shadow value set memory
`timescale 1ns/1ps
interface ptvs_shadow_if;
  logic [ptvs_pkg::MEM_AW-1:0] wr_addr;
  logic [2:0] wr_lane;
  logic [ptvs_pkg::DATA_W-1:0] wr_data;
  logic [ptvs_pkg::MEM_AW-1:0] rd_addr;
  logic rd_en;
  logic [ptvs_pkg::MEM_W-1:0] rd_data;
  modport ctrl (output wr_addr, wr_lane, wr_data, rd_addr, rd_en, input rd_data);
  modport mem (input wr_addr, wr_lane, wr_data, rd_addr, rd_en, output rd_data);
endinterface

/* File: ptvs_shadow_mem.sv */
// Shadow value set memory: one word per step holding step, core and main values
`timescale 1ns/1ps
module ptvs_shadow_mem (
  // Clock and enable
  input wire logic sys_clk_in,
  input wire logic clk_en_in,
  // Access port
  ptvs_shadow_if.mem sh
);
  import ptvs_pkg::*;
  logic [MEM_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [MEM_W-1:0] next_rd_data;
  logic [MEM_W-1:0] rd_q;

  // Read data come from a register; no reset so the array maps to RAM
  always_comb begin
    next_rd_data = sh.rd_en ? mem[sh.rd_addr] : rd_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      rd_q <= next_rd_data;
      for (int l = 0; l < 3; l++) begin
        if (sh.wr_lane[l]) begin
          mem[sh.wr_addr][l*DATA_W +: DATA_W] <= sh.wr_data;
        end
      end
    end
  end

  assign sh.rd_data = rd_q;
endmodule
